// >>> inc/gbc_pkg.sv
// Package for the banked general-purpose pin controller.
// Assumes one core clock; all widths and offsets are fixed here.
package gbc_pkg;

	// ==========================================================
	// Geometry
	localparam int NUM_PINS  = 104;
	localparam int BANK_W    = 16;
	localparam int NUM_BANKS = 7;
	localparam int PAD_W     = NUM_BANKS * BANK_W;
	localparam int NUM_DED   = 10;
	localparam int LAST_POP  = NUM_PINS - (NUM_BANKS - 1) * BANK_W;

	// ==========================================================
	// Register bus
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int BANK_LSB  = 6;
	localparam int BANK_MSB  = 8;

	// Byte offsets inside one bank window
	localparam logic [5:0] OFF_DIR  = 6'h00;
	localparam logic [5:0] OFF_OUT  = 6'h04;
	localparam logic [5:0] OFF_SET  = 6'h08;
	localparam logic [5:0] OFF_CLR  = 6'h0C;
	localparam logic [5:0] OFF_IN   = 6'h10;
	localparam logic [5:0] OFF_RISE = 6'h14;
	localparam logic [5:0] OFF_FALL = 6'h18;
	localparam logic [5:0] OFF_STAT = 6'h1C;
	localparam logic [5:0] OFF_MASK = 6'h20;

	// ==========================================================
	// Reset values
	localparam logic [PAD_W-1:0] RST_DIR  = '0;
	localparam logic [PAD_W-1:0] RST_OUT  = '0;
	localparam logic [PAD_W-1:0] RST_EDGE = '0;
	localparam logic [PAD_W-1:0] RST_MASK = '0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} gbc_bus_s;

	typedef struct packed {
		logic [PAD_W-1:0]     meta;
		logic [PAD_W-1:0]     sync;
		logic [PAD_W-1:0]     prev;
		logic [PAD_W-1:0]     dir;
		logic [PAD_W-1:0]     out;
		logic [PAD_W-1:0]     riseEn;
		logic [PAD_W-1:0]     fallEn;
		logic [PAD_W-1:0]     stat;
		logic [PAD_W-1:0]     mask;
		logic [DATA_W-1:0]    rdData;
		logic [NUM_DED-1:0]   pinIrq;
		logic [NUM_DED-1:0]   pinDma;
		logic [NUM_BANKS-1:0] bankIrq;
		logic [NUM_BANKS-1:0] bankDma;
		logic                 irq;
	} gbc_state_s;

endpackage

// >>> verilog/gbc_bank_ctrl.sv
// Banked general-purpose pin controller: direction, drive, sensing, edge events.
// Assumes a word-wide register port with read data one cycle after the strobe,
// and pin inputs that may be asynchronous to core_clk.
//
// Operation
// [RULE1] Each pin individually input or output
// [RULE2] Output pin drives its output register bit
// [RULE3] Input pin level readable in input register
// [RULE4] 104 pins in seven banks of sixteen
// [RULE5] Ten dedicated interrupts for pins zero to nine
// [RULE6] Seven per-bank aggregated interrupts
// [RULE7] Rising, falling or both edges selectable
// [RULE8] Ten dedicated DMA events, same edge conditions
// [RULE9] Seven per-bank aggregated DMA events
// [RULE10] Write-one set and clear registers
// [RULE11] Input and output registers at different offsets
// [RULE12] Direct output write updates whole bank
// [RULE13] Output read returns driven levels
// [RULE14] Input register shows real pin level always
// [RULE15] Two-stage synchroniser, then sample-compare edges
// [RULE16] Single write per cycle, deterministic per bit
`timescale 1ns/1ps
`default_nettype none

module gbc_bank_ctrl
	import gbc_pkg::*;
(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Register port
	input  wire logic [ADDR_W-1:0]     regAddr,
	input  wire logic [DATA_W-1:0]     regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic      [DATA_W-1:0]     regRdata,
	// Pins
	input  wire logic [NUM_PINS-1:0]   pinIn,
	output logic      [NUM_PINS-1:0]   pinOut,
	output logic      [NUM_PINS-1:0]   pinOe,
	// Events
	output logic      [NUM_DED-1:0]    pinIrq,
	output logic      [NUM_BANKS-1:0]  bankIrq,
	output logic      [NUM_DED-1:0]    pinDmaEvt,
	output logic      [NUM_BANKS-1:0]  bankDmaEvt,
	output logic                       irq
);

	// ==========================================================
	// Helpers
	function automatic logic bankOk(input logic [2:0] b);
		bankOk = (32'(b) < NUM_BANKS);
	endfunction

	// Unpopulated top of the last bank reads zero and ignores writes
	function automatic logic [BANK_W-1:0] popMask(input logic [2:0] b);
		if (32'(b) == NUM_BANKS - 1) begin
			popMask = BANK_W'((1 << LAST_POP) - 1);
		end else begin
			popMask = '1;
		end
	endfunction

	// ==========================================================
	// Select bit of each register in the one-hot decode
	localparam int SEL_DIR  = 0;
	localparam int SEL_OUT  = 1;
	localparam int SEL_SET  = 2;
	localparam int SEL_CLR  = 3;
	localparam int SEL_IN   = 4;
	localparam int SEL_RISE = 5;
	localparam int SEL_FALL = 6;
	localparam int SEL_STAT = 7;
	localparam int SEL_MASK = 8;
	localparam int SEL_N    = 9;

	// ==========================================================
	// Decode helpers
	function automatic logic [2:0] bankOf(
		input logic [ADDR_W-1:0] a
	);
		bankOf = a[BANK_MSB:BANK_LSB];
	endfunction

	// Bank 7 and high address bits are holes: writes dropped, reads zero
	function automatic logic addrHit(
		input logic [ADDR_W-1:0] a
	);
		addrHit = bankOk(bankOf(a)) && (a[ADDR_W-1:BANK_MSB+1] == '0);
	endfunction

	// Byte lanes are ignored; every register is a whole word
	function automatic logic [5:0] wordOff(
		input logic [ADDR_W-1:0] a
	);
		wordOff = {a[5:2], 2'b00};
	endfunction

	// One-hot register select, shared by the write and the read path
	function automatic logic [SEL_N-1:0] regSel(
		input logic [5:0] o
	);
		regSel = '0;
		if (o == OFF_DIR) begin
			regSel[SEL_DIR] = 1'b1;
		end else if (o == OFF_OUT) begin
			regSel[SEL_OUT] = 1'b1;
		end else if (o == OFF_SET) begin
			regSel[SEL_SET] = 1'b1;
		end else if (o == OFF_CLR) begin
			regSel[SEL_CLR] = 1'b1;
		end else if (o == OFF_IN) begin
			regSel[SEL_IN] = 1'b1;
		end else if (o == OFF_RISE) begin
			regSel[SEL_RISE] = 1'b1;
		end else if (o == OFF_FALL) begin
			regSel[SEL_FALL] = 1'b1;
		end else if (o == OFF_STAT) begin
			regSel[SEL_STAT] = 1'b1;
		end else if (o == OFF_MASK) begin
			regSel[SEL_MASK] = 1'b1;
		end
	endfunction

	// ==========================================================
	// Bit operations
	// Write-one set: ones force bits high, zeros leave them alone
	function automatic logic [BANK_W-1:0] setBits(
		input logic [BANK_W-1:0] cur,
		input logic [BANK_W-1:0] ones
	);
		setBits = cur | ones;
	endfunction

	// Write-one clear: ones force bits low, zeros leave them alone
	function automatic logic [BANK_W-1:0] clrBits(
		input logic [BANK_W-1:0] cur,
		input logic [BANK_W-1:0] ones
	);
		clrBits = cur & ~ones;
	endfunction

	// ==========================================================
	// Edge detection
	function automatic logic [PAD_W-1:0] edgeOf(
		input logic [PAD_W-1:0] now,
		input logic [PAD_W-1:0] was,
		input logic [PAD_W-1:0] onRise,
		input logic [PAD_W-1:0] onFall
	);
		edgeOf = (now & ~was & onRise) | (~now & was & onFall);
	endfunction

	// ==========================================================
	// Field helpers
	function automatic logic [BANK_W-1:0] sliceOf(
		input logic [PAD_W-1:0] v,
		input logic [2:0]       b
	);
		sliceOf = v[32'(b)*BANK_W +: BANK_W];
	endfunction

	// Replace one bank slice; the other banks pass through untouched
	function automatic logic [PAD_W-1:0] putSlice(
		input logic [PAD_W-1:0]  v,
		input logic [2:0]        b,
		input logic [BANK_W-1:0] w
	);
		putSlice = v;
		putSlice[32'(b)*BANK_W +: BANK_W] = w;
	endfunction

	// ==========================================================
	// State
	gbc_bus_s             bus;
	gbc_state_s           s_q;
	gbc_state_s           s_d;
	logic [PAD_W-1:0]     padIn;
	logic [PAD_W-1:0]     popAll;
	logic [PAD_W-1:0]     edges;
	logic [NUM_BANKS-1:0] bankEdge;
	logic [NUM_DED-1:0]   dedEdge;
	logic [2:0]           bank;
	logic [5:0]           off;
	logic [SEL_N-1:0]     sel;
	logic                 wrHit;
	logic                 rdHit;
	logic [BANK_W-1:0]    wd;
	logic [BANK_W-1:0]    pm;

	assign bus.addr  = regAddr;
	assign bus.wdata = regWdata;
	assign bus.wr    = regWr;
	assign bus.rd    = regRd;

	// Pins beyond the last populated one never raise an edge
	assign popAll = {{(PAD_W-NUM_PINS){1'b0}}, {NUM_PINS{1'b1}}};

	// [RULE7] per-pin edge select
	// [RULE15] compare consecutive samples
	assign edges = edgeOf(s_q.sync, s_q.prev, s_q.riseEn, s_q.fallEn) & popAll;

	// ==========================================================
	// Event summaries
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			// [RULE6] one OR tree per bank
			assign bankEdge[gi] = |edges[gi*BANK_W +: BANK_W];
		end
		for (gi = 0; gi < NUM_DED; gi++) begin : g_ded
			// [RULE5] dedicated pins of bank zero
			assign dedEdge[gi] = edges[gi];
		end
	endgenerate

	// ==========================================================
	// Next state
	always_comb begin
		s_d   = s_q;
		// [RULE4] flat bank layout
		padIn = {{(PAD_W-NUM_PINS){1'b0}}, pinIn};

		// [RULE15] meta feeds only sync
		// Third stage keeps the previous sample for the edge compare
		s_d.meta = padIn;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;

		// Decode once; both strobes share it
		bank  = bankOf(bus.addr);
		off   = wordOff(bus.addr);
		sel   = regSel(off);
		wrHit = bus.wr && addrHit(bus.addr);
		rdHit = bus.rd && addrHit(bus.addr);
		pm    = popMask(bank);
		wd    = bus.wdata[BANK_W-1:0] & pm;
		s_d.rdData = '0;

		// Register writes; one strobe per cycle so no write can race another
		if (wrHit) begin
			if (sel[SEL_DIR]) begin
				// [RULE1] direction per pin
				s_d.dir = putSlice(s_q.dir, bank, wd);
			end else if (sel[SEL_OUT]) begin
				// [RULE12] whole bank at once
				s_d.out = putSlice(s_q.out, bank, wd);
			end else if (sel[SEL_SET]) begin
				// [RULE10] write-one set
				// [RULE16] per-bit merge
				s_d.out = putSlice(s_q.out, bank, setBits(sliceOf(s_q.out, bank), wd));
			end else if (sel[SEL_CLR]) begin
				// [RULE10] write-one clear
				s_d.out = putSlice(s_q.out, bank, clrBits(sliceOf(s_q.out, bank), wd));
			end else if (sel[SEL_RISE]) begin
				// [RULE7] rising edge enables
				s_d.riseEn = putSlice(s_q.riseEn, bank, wd);
			end else if (sel[SEL_FALL]) begin
				// [RULE7] falling edge enables
				s_d.fallEn = putSlice(s_q.fallEn, bank, wd);
			end else if (sel[SEL_STAT]) begin
				// Write one to clear a sticky bit
				s_d.stat = putSlice(s_q.stat, bank, clrBits(sliceOf(s_q.stat, bank), wd));
			end else if (sel[SEL_MASK]) begin
				s_d.mask = putSlice(s_q.mask, bank, wd);
			end
		end

		// Set after clear so a same-cycle edge is never lost
		s_d.stat = s_d.stat | edges;

		// Register reads, data valid the next cycle only
		if (rdHit) begin
			if (sel[SEL_DIR]) begin
				s_d.rdData[BANK_W-1:0] = sliceOf(s_q.dir, bank);
			end else if (sel[SEL_OUT]) begin
				// [RULE13] driven levels, not pins
				s_d.rdData[BANK_W-1:0] = sliceOf(s_q.out, bank);
			end else if (sel[SEL_IN]) begin
				// [RULE3] sensed level
				// [RULE11] separate offset
				// [RULE14] sensed even while driving
				s_d.rdData[BANK_W-1:0] = sliceOf(s_q.sync, bank) & pm;
			end else if (sel[SEL_RISE]) begin
				s_d.rdData[BANK_W-1:0] = sliceOf(s_q.riseEn, bank);
			end else if (sel[SEL_FALL]) begin
				s_d.rdData[BANK_W-1:0] = sliceOf(s_q.fallEn, bank);
			end else if (sel[SEL_STAT]) begin
				s_d.rdData[BANK_W-1:0] = sliceOf(s_q.stat, bank);
			end else if (sel[SEL_MASK]) begin
				s_d.rdData[BANK_W-1:0] = sliceOf(s_q.mask, bank);
			end
		end

		// [RULE5] dedicated interrupt pulses
		s_d.pinIrq  = dedEdge;
		// [RULE8] dedicated DMA pulses
		s_d.pinDma  = dedEdge;
		// [RULE6] bank aggregate interrupts
		s_d.bankIrq = bankEdge;
		// [RULE9] bank aggregate DMA events
		s_d.bankDma = bankEdge;
		s_d.irq     = |(s_d.stat & s_d.mask);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q        <= '0;
			s_q.dir    <= RST_DIR;
			s_q.out    <= RST_OUT;
			s_q.riseEn <= RST_EDGE;
			s_q.fallEn <= RST_EDGE;
			s_q.mask   <= RST_MASK;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign regRdata   = s_q.rdData;
	// [RULE2] drive output register onto pins
	assign pinOut     = s_q.out[NUM_PINS-1:0];
	assign pinOe      = s_q.dir[NUM_PINS-1:0];
	assign pinIrq     = s_q.pinIrq;
	assign pinDmaEvt  = s_q.pinDma;
	assign bankIrq    = s_q.bankIrq;
	assign bankDmaEvt = s_q.bankDma;
	assign irq        = s_q.irq;

endmodule

`default_nettype wire

// >>> tb/gbc_bank_ctrl_assertions.sv
// Port checker for the banked pin controller.
// Assumes one core clock and the async high reset of the design.
`timescale 1ns/1ps
`default_nettype none
module gbc_bank_chk
	import gbc_pkg::*;
(
	// Clock and reset
	input wire logic                 core_clk,
	input wire logic                 rst,
	// Register port
	input wire logic [ADDR_W-1:0]    regAddr,
	input wire logic [DATA_W-1:0]    regWdata,
	input wire logic                 regWr,
	input wire logic                 regRd,
	input wire logic [DATA_W-1:0]    regRdata,
	// Pins and events
	input wire logic [NUM_PINS-1:0]  pinOut,
	input wire logic [NUM_PINS-1:0]  pinOe,
	input wire logic [NUM_DED-1:0]   pinIrq,
	input wire logic [NUM_BANKS-1:0] bankIrq,
	input wire logic [NUM_DED-1:0]   pinDmaEvt,
	input wire logic [NUM_BANKS-1:0] bankDmaEvt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ========================
	// Properties
	property p_dirWr; regWr && regAddr == 12'h000 |=> pinOe[15:0] == $past(regWdata[15:0]); endproperty
	a_dirWr: assert property (p_dirWr) else $error("direction write lost");
	property p_outWr; regWr && regAddr == 12'h004 |=> pinOut[15:0] == $past(regWdata[15:0]); endproperty
	a_outWr: assert property (p_outWr) else $error("output write lost");
	property p_setWr; regWr && regAddr == 12'h008 |=> pinOut[15:0] == ($past(pinOut[15:0]) | $past(regWdata[15:0])); endproperty
	a_setWr: assert property (p_setWr) else $error("set write wrong");
	property p_outRd; regRd && regAddr == 12'h004 |=> regRdata[15:0] == $past(pinOut[15:0]); endproperty
	a_outRd: assert property (p_outRd) else $error("output readback wrong");
	property p_dedDma; pinDmaEvt == pinIrq; endproperty
	a_dedDma: assert property (p_dedDma) else $error("pin dma differs");
	property p_bankDma; bankDmaEvt == bankIrq; endproperty
	a_bankDma: assert property (p_bankDma) else $error("bank dma differs");
	property p_dedBank; |pinIrq |-> bankIrq[0]; endproperty
	a_dedBank: assert property (p_dedBank) else $error("bank zero event missing");
	property p_rdIdle; !$past(regRd) |-> regRdata == '0; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
endmodule
bind gbc_bank_ctrl gbc_bank_chk chk_u (.core_clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
	.regRdata, .pinOut, .pinOe, .pinIrq, .bankIrq, .pinDmaEvt, .bankDmaEvt);
`default_nettype wire

// >>> tb/gbc_pin_model.sv
// External devices on the pins: pull-ups and open-drain pull-downs.
// Assumes pinOe high while the design drives a pin.
`timescale 1ns/1ps
`default_nettype none
module gbc_pin_model
	import gbc_pkg::*;
(
	// Design side
	input  wire logic [NUM_PINS-1:0] pinOut,
	input  wire logic [NUM_PINS-1:0] pinOe,
	// Bench side
	input  wire logic [NUM_PINS-1:0] extLvl,
	output logic      [NUM_PINS-1:0] pinIn
);
	// ========================
	// Wired level
	// Wired-AND, so a low driver wins
	assign pinIn = extLvl & (~pinOe | pinOut);
endmodule
`default_nettype wire

// >>> tb/gbc_bank_ctrl_test.sv
// Bench for the banked pin controller.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gbc_bank_ctrl_test
	import gbc_pkg::*;
;
	// ========================
	// Signals
	logic                 core_clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 regWr = 1'b0;
	logic                 regRd = 1'b0;
	logic                 irq;
	logic [ADDR_W-1:0]    regAddr = '0;
	logic [DATA_W-1:0]    regWdata = '0;
	logic [DATA_W-1:0]    regRdata;
	logic [NUM_PINS-1:0]  pinIn, pinOut, pinOe;
	logic [NUM_PINS-1:0]  extLvl = '1;
	logic [NUM_DED-1:0]   pinIrq, pinDmaEvt;
	logic [NUM_BANKS-1:0] bankIrq, bankDmaEvt;
	int                   miscompares = 0;
	int                   n_checks = 0;
	gbc_bank_ctrl dut_u (.core_clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.pinIn, .pinOut, .pinOe, .pinIrq, .bankIrq, .pinDmaEvt, .bankDmaEvt, .irq);
	gbc_pin_model pins_u (.pinOut, .pinOe, .extLvl, .pinIn);
	always #4 core_clk = ~core_clk;
	// ========================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= {16'h0000, d};
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		chk(regRdata, {16'h0000, e});
	endtask
	// Three edges: two sync stages, then the edge flop
	task automatic pins(input logic [31:0] v);
		@(posedge core_clk);
		extLvl[31:0] <= v;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	// ========================
	// Scenarios
	task automatic t_drive;
		wr(12'h000, 16'hFFFF);
		wr(12'h004, 16'hA5A5);
		@(negedge core_clk);
		chk(pinOe[15:0], 32'h0000FFFF);
		chk(pinOut[15:0], 32'h0000A5A5);
		wr(12'h008, 16'h0F00);
		wr(12'h00C, 16'h0005);
		rd(12'h004, 16'hAFA0);
		pins(32'h3C5A00FF);
		rd(12'h010, 16'h00A0);
		rd(12'h004, 16'hAFA0);
		rd(12'h050, 16'h3C5A);
		rd(12'h190, 16'h00FF);
		rd(12'h1D0, 16'h0000);
		$display("drive done");
	endtask
	task automatic t_events;
		wr(12'h000, 16'h0000);
		pins(32'h3C5A0000);
		chk(pinIrq, 32'h0);
		wr(12'h014, 16'h0001);
		wr(12'h018, 16'h0002);
		wr(12'h020, 16'h0001);
		wr(12'h054, 16'h0001);
		pins(32'h3C5B0003);
		chk({bankIrq, pinIrq}, 32'h00000C01);
		chk(irq, 32'h1);
		pins(32'h3C5B0001);
		chk({bankDmaEvt, pinDmaEvt}, 32'h00000402);
		rd(12'h01C, 16'h0003);
		wr(12'h01C, 16'h0001);
		@(negedge core_clk);
		chk(irq, 32'h0);
		wr(12'h020, 16'h0002);
		@(negedge core_clk);
		chk(irq, 32'h1);
		$display("events done");
	endtask
	task automatic conclude;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ========================
	// Sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		chk(pinOe[31:0] | pinOut[31:0], 32'h0);
		t_drive();
		t_events();
		conclude();
	end
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
